// ---- arm_mapper.v ----
// Purpose : alarm relay mapper, 32 radio channels to four relays and a horn
// Assumes : packet and alarm reset inputs synchronous to pclk
// Notes   : registers reached over APB, one word each
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "arm_map.vh"
module arm_mapper #(
  parameter integer NCH      = 32,
  parameter integer SEC_DIV  = `ARM_CLK_HZ,
  parameter integer MIN_SECS = `ARM_MIN_S,
  parameter integer PULSE_DIV = `ARM_CLK_HZ / (2 * `ARM_PULSE_HZ)
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        pkt_valid,
  input  wire [4:0]  pkt_unit,
  input  wire [4:0]  pkt_net,
  input  wire        pkt_fault,
  input  wire        pkt_al1,
  input  wire        pkt_al2,
  input  wire        pkt_al3,
  input  wire        alarm_reset,
  output reg         repeat_tx,
  output reg  [3:0]  relay_out,
  output reg         horn_relay,
  output reg  [4:0]  hop_channel,
  output reg  [4:0]  system_id,
  output reg         encrypt_en,
  output reg         high_band
);
  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  reg  [4:0]  net_q;
  reg         rpt_en_q;
  reg  [5:0]  nact_q;
  reg  [6:0]  rrefr_q;
  reg  [6:0]  hrefr_q;
  reg  [8:0]  wake_q;
  reg  [31:0] act_q;
  reg  [2:0]  trip_q  [0:3];
  reg  [3:0]  fs_q;
  reg  [3:0]  ack_q;
  reg  [1:0]  hmode_q [0:3];
  reg  [31:0] mask_q  [0:3];
  reg  [4:0]  unit_q  [0:NCH-1];
  reg  [3:0]  al_q    [0:NCH-1];
  reg  [10:0] wd_q    [0:NCH-1];
  reg  [31:0] cerr_q;
  reg  [10:0] wdmax_q;
  reg  [24:0] sec_q;
  reg         sec_tick_q;
  reg  [5:0]  min_q;
  reg         min_tick_q;
  reg  [22:0] pls_q;
  reg         pls_lvl_q;
  reg  [3:0]  silenced_q;
  reg  [6:0]  rtmr_q  [0:3];
  reg         hsil_q;
  reg  [6:0]  htmr_q;
  wire [31:0] chan_ok;
  wire [3:0]  trip;
  // span in seconds, five wakeup intervals
  wire [31:0] span_w = `ARM_WD_SPAN * wake_q;
  wire [10:0] span = span_w[10:0];
  wire        wr = psel & penable & pwrite;
  wire        net_ok = pkt_valid && (pkt_net == net_q);
  // separate loop indices keep the processes from waking each other
  integer     i;
  integer     i_rd;
  integer     i_mx;
  integer     i_hn;
  integer     i_ot;
  genvar      g;

  // ---------------------------------------------------------------
  // apb register access
  // ---------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      net_q    <= 5'h00;
      rpt_en_q <= 1'b0;
      nact_q   <= `ARM_NACT_MIN;
      rrefr_q  <= 7'h00;
      hrefr_q  <= `ARM_HREFR_RST;
      wake_q   <= `ARM_WAKE_RST;
      act_q    <= 32'hFFFFFFFF;
      fs_q     <= 4'h0;
      ack_q    <= 4'h0;
      for (i = 0; i < 4; i = i + 1) begin
        trip_q[i]  <= `ARM_TRIP_LVL1;
        hmode_q[i] <= `ARM_HORN_NONE;
        mask_q[i]  <= 32'h00000000;
      end
      for (i = 0; i < NCH; i = i + 1) begin
        unit_q[i] <= i[4:0];
      end
    end else if (wr && pready) begin
      case (paddr)
        `ARM_CFG_OFS: begin
          if (pwdata[4:0] <= `ARM_NET_LAST) begin
            net_q <= pwdata[4:0];
          end
          rpt_en_q <= pwdata[5];
          if (pwdata[13:8] >= `ARM_NACT_MIN && pwdata[13:8] <= `ARM_NACT_MAX) begin
            nact_q <= pwdata[13:8];
          end
          if (pwdata[22:16] <= `ARM_REFR_MAX) begin
            rrefr_q <= pwdata[22:16];
          end
          if (pwdata[30:24] <= `ARM_REFR_MAX) begin
            hrefr_q <= pwdata[30:24];
          end
        end
        `ARM_ACT_OFS: begin
          for (i = 0; i < 32; i = i + 1) begin
            if (i < nact_q) begin
              act_q[i] <= pwdata[i];
            end
          end
        end
        `ARM_WDMAX_OFS: begin
          if (pwdata[8:0] != 9'h000 && pwdata[8:0] <= `ARM_WAKE_MAX_S) begin
            wake_q <= pwdata[8:0];
          end
        end
        default: begin
          for (i = 0; i < 4; i = i + 1) begin
            if (paddr == `ARM_RLY_OFS + 4 * i) begin
              trip_q[i]  <= pwdata[2:0];
              fs_q[i]    <= pwdata[4];
              ack_q[i]   <= pwdata[5];
              hmode_q[i] <= pwdata[9:8];
            end
            if (paddr == `ARM_MASK_OFS + 4 * i) begin
              mask_q[i] <= pwdata;
            end
          end
          for (i = 0; i < NCH; i = i + 1) begin
            if (paddr == `ARM_UNIT_OFS + 4 * i) begin
              unit_q[i] <= pwdata[4:0] - 5'h01;
            end
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // read path, no wait states
  // ---------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h00000000;
        case (paddr)
          `ARM_CFG_OFS:   prdata <= {1'b0, hrefr_q, 1'b0, rrefr_q, 2'h0, nact_q,
                                     2'h0, rpt_en_q, net_q};
          `ARM_ACT_OFS:   prdata <= act_q;
          `ARM_STAT_OFS:  prdata <= {26'h0, horn_relay, relay_out, 1'b0} | {hsil_q,
                                     silenced_q, 27'h0};
          `ARM_WDMAX_OFS: prdata <= {5'h0, wdmax_q, 7'h0, wake_q};
          `ARM_CERR_OFS:  prdata <= cerr_q;
          default: begin
            for (i_rd = 0; i_rd < 4; i_rd = i_rd + 1) begin
              if (paddr == `ARM_RLY_OFS + 4 * i_rd) begin
                prdata <= {22'h0, hmode_q[i_rd], 2'h0, ack_q[i_rd], fs_q[i_rd],
                           1'b0, trip_q[i_rd]};
              end
              if (paddr == `ARM_MASK_OFS + 4 * i_rd) begin
                prdata <= mask_q[i_rd];
              end
            end
            for (i_rd = 0; i_rd < NCH; i_rd = i_rd + 1) begin
              if (paddr == `ARM_UNIT_OFS + 4 * i_rd) begin
                prdata <= {27'h0, unit_q[i_rd] + 5'h01};
              end
            end
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // time base: seconds, minutes, pulse rate
  // ---------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_q      <= 25'h0000000;
      sec_tick_q <= 1'b0;
      min_q      <= 6'h00;
      min_tick_q <= 1'b0;
      pls_q      <= 23'h000000;
      pls_lvl_q  <= 1'b0;
    end else begin
      sec_tick_q <= (sec_q == SEC_DIV - 1);
      sec_q      <= (sec_q == SEC_DIV - 1) ? 25'h0000000 : sec_q + 25'h0000001;
      min_tick_q <= 1'b0;
      if (sec_tick_q) begin
        min_tick_q <= (min_q == MIN_SECS - 1);
        min_q      <= (min_q == MIN_SECS - 1) ? 6'h00 : min_q + 6'h01;
      end
      if (pls_q == PULSE_DIV - 1) begin
        pls_q     <= 23'h000000;
        pls_lvl_q <= ~pls_lvl_q;
      end else begin
        pls_q <= pls_q + 23'h000001;
      end
    end
  end

  // ---------------------------------------------------------------
  // per-channel alarm state and watchdog
  // ---------------------------------------------------------------
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      wire hit = net_ok && (pkt_unit == unit_q[g] + 5'h01);
      assign chan_ok[g] = act_q[g] && (g < nact_q);
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          wd_q[g]     <= 11'h000;
          al_q[g]     <= 4'h0;
          cerr_q[g]   <= 1'b0;
        end else if (!chan_ok[g]) begin
          wd_q[g]   <= 11'h000;
          al_q[g]   <= 4'h0;
          cerr_q[g] <= 1'b0;
        end else if (hit) begin
          wd_q[g]   <= 11'h000;
          al_q[g]   <= {pkt_fault, pkt_al3, pkt_al2, pkt_al1};
          cerr_q[g] <= 1'b0;
        end else if (sec_tick_q) begin
          if (wd_q[g] >= span - 11'h001) begin
            wd_q[g]   <= span;
            cerr_q[g] <= 1'b1;
          end else begin
            wd_q[g] <= wd_q[g] + 11'h001;
          end
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // watchdog summary
  // ---------------------------------------------------------------
  reg [10:0] max_d;
  always @* begin
    max_d = 11'h000;
    // only active channels feed the summary
    for (i_mx = 0; i_mx < NCH; i_mx = i_mx + 1) begin
      if (chan_ok[i_mx] && wd_q[i_mx] > max_d) begin
        max_d = wd_q[i_mx];
      end
    end
  end

  // ---------------------------------------------------------------
  // relay trip, acknowledge, refresh
  // ---------------------------------------------------------------
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_rly
      reg     hitc;
      integer k;
      always @* begin
        hitc = 1'b0;
        for (k = 0; k < NCH; k = k + 1) begin
          if (chan_ok[k] && mask_q[g][k]) begin
            case (trip_q[g])
              `ARM_TRIP_LVL1: hitc = hitc | al_q[k][0];
              `ARM_TRIP_LVL2: hitc = hitc | al_q[k][1];
              `ARM_TRIP_LVL3: hitc = hitc | al_q[k][2];
              `ARM_TRIP_FLT:  hitc = hitc | al_q[k][3] | cerr_q[k];
              `ARM_TRIP_ANY:  hitc = hitc | (|al_q[k][2:0]);
              default:       hitc = hitc;
            endcase
          end
        end
      end
      assign trip[g] = hitc;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          silenced_q[g] <= 1'b0;
          rtmr_q[g]     <= 7'h00;
        end else if (!trip[g]) begin
          silenced_q[g] <= 1'b0;
          rtmr_q[g]     <= 7'h00;
        end else if (alarm_reset && ack_q[g] && !silenced_q[g]) begin
          silenced_q[g] <= 1'b1;
          rtmr_q[g]     <= 7'h00;
        end else if (silenced_q[g] && min_tick_q && rrefr_q != 7'h00) begin
          if (rtmr_q[g] >= rrefr_q - 7'h01) begin
            silenced_q[g] <= 1'b0;
            rtmr_q[g]     <= 7'h00;
          end else begin
            rtmr_q[g] <= rtmr_q[g] + 7'h01;
          end
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // horn and outputs
  // ---------------------------------------------------------------
  reg steady_c;
  reg pulse_c;
  always @* begin
    steady_c = 1'b0;
    pulse_c  = 1'b0;
    for (i_hn = 0; i_hn < 4; i_hn = i_hn + 1) begin
      if (trip[i_hn] && !silenced_q[i_hn]) begin
        steady_c = steady_c | (hmode_q[i_hn] == `ARM_HORN_STEADY);
        pulse_c  = pulse_c | (hmode_q[i_hn] == `ARM_HORN_PULSE);
      end
    end
  end
  wire horn_req = steady_c | pulse_c;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hsil_q      <= 1'b0;
      htmr_q      <= 7'h00;
      wdmax_q     <= 11'h000;
      relay_out   <= 4'h0;
      horn_relay  <= 1'b0;
      repeat_tx   <= 1'b0;
      hop_channel <= 5'h01;
      system_id   <= 5'h01;
      encrypt_en  <= 1'b0;
      high_band   <= 1'b0;
    end else begin
      wdmax_q <= max_d;
      if (!horn_req) begin
        hsil_q <= 1'b0;
        htmr_q <= 7'h00;
      end else if (alarm_reset && !hsil_q) begin
        hsil_q <= 1'b1;
        htmr_q <= 7'h00;
      end else if (hsil_q && min_tick_q && hrefr_q != 7'h00) begin
        if (htmr_q >= hrefr_q - 7'h01) begin
          hsil_q <= 1'b0;
          htmr_q <= 7'h00;
        end else begin
          htmr_q <= htmr_q + 7'h01;
        end
      end
      // failsafe flips the drive polarity
      for (i_ot = 0; i_ot < 4; i_ot = i_ot + 1) begin
        relay_out[i_ot] <= (trip[i_ot] && !silenced_q[i_ot]) ^ fs_q[i_ot];
      end
      horn_relay  <= !hsil_q && (steady_c || (pulse_c && pls_lvl_q));
      repeat_tx   <= rpt_en_q && net_ok;
      hop_channel <= net_q + 5'h01;
      system_id   <= net_q + 5'h01;
      encrypt_en  <= (net_q >= `ARM_NET_ENC);
      high_band   <= (net_q >= `ARM_NET_HIGH);
    end
  end
endmodule // arm_mapper

// ---- arm_map.vh ----
// Purpose : constants for the alarm relay mapper
// Assumes : 25 MHz pclk, APB with 32-bit data
// Notes   : one rule per line below
`ifndef ARM_MAP_VH
`define ARM_MAP_VH
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define ARM_CFG_OFS     12'h000
`define ARM_ACT_OFS     12'h004
`define ARM_STAT_OFS    12'h008
`define ARM_WDMAX_OFS   12'h00C
`define ARM_CERR_OFS    12'h010
`define ARM_RLY_OFS     12'h020
`define ARM_MASK_OFS    12'h030
`define ARM_UNIT_OFS    12'h080
// ---------------------------------------------------------------
// fields and codes
// ---------------------------------------------------------------
`define ARM_TRIP_LVL1   3'h0
`define ARM_TRIP_LVL2   3'h1
`define ARM_TRIP_LVL3   3'h2
`define ARM_TRIP_FLT    3'h3
`define ARM_TRIP_ANY    3'h4
`define ARM_HORN_NONE   2'h0
`define ARM_HORN_PULSE  2'h1
`define ARM_HORN_STEADY 2'h2
`define ARM_NET_ENC     5'h0C
`define ARM_NET_HIGH    5'h12
`define ARM_NET_LAST    5'h19
`define ARM_REFR_MAX    7'h78
`define ARM_HREFR_RST   7'h0F
`define ARM_NACT_MIN    6'h01
`define ARM_NACT_MAX    6'h20
`define ARM_WAKE_RST    9'h12C
`define ARM_WD_SPAN     5
`define ARM_WAKE_MAX_S  300
`define ARM_MIN_S       60
`define ARM_CLK_HZ      25000000
`define ARM_PULSE_HZ    2
`endif

// ---- arm_mapper_sva.sv ----
// Purpose : port checker for arm_mapper
// Assumes : one clock, async active-low reset
// Notes   : network outputs, repeat cause, bus timing and error response only
`timescale 1ns/10ps
module arm_mapper_chk (
  input wire       pclk,
  input wire       presetn,
  input wire       psel,
  input wire       penable,
  input wire       pwrite,
  input wire       pready,
  input wire       pslverr,
  input wire       pkt_valid,
  input wire       repeat_tx,
  input wire [4:0] hop_channel,
  input wire [4:0] system_id,
  input wire       encrypt_en,
  input wire       high_band
);
  wire wr_done = psel & penable & pwrite & pready;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_hop_range: assert property (hop_channel >= 5'h01 && hop_channel <= 5'h1A)
    else $error("hop channel out of range");
  a_hop_sysid: assert property (hop_channel == system_id)
    else $error("hop channel and system id differ");
  a_encrypt_net: assert property (encrypt_en == (hop_channel >= 5'h0D))
    else $error("encryption does not follow network");
  a_band_net: assert property (high_band == (hop_channel >= 5'h13))
    else $error("band does not follow network");
  a_net_cause: assert property (!$stable(hop_channel) |-> $past(wr_done) || $past(wr_done, 2))
    else $error("network changed without a write");
  a_ready_wait: assert property ((psel && !penable) |-> !pready ##1 pready ##1 !pready)
    else $error("ready not one cycle after setup");
  a_repeat_cause: assert property (repeat_tx |-> $past(pkt_valid))
    else $error("repeat without a packet");
  a_slverr_low: assert property (!pslverr)
    else $error("error response seen");
endmodule // arm_mapper_chk
bind arm_mapper arm_mapper_chk arm_mapper_chk_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .pslverr(pslverr), .pkt_valid(pkt_valid), .repeat_tx(repeat_tx),
  .hop_channel(hop_channel), .system_id(system_id), .encrypt_en(encrypt_en),
  .high_band(high_band));

// ---- arm_remote_model.sv ----
// Purpose : remote gas monitors sending alarm broadcast packets
// Assumes : one packet per send call, synchronous to pclk
// Notes   : idle fields show the inverse of the last packet
`timescale 1ns/10ps
module arm_remote_model (
  input  wire       pclk,
  output wire       pkt_valid,
  output wire [4:0] pkt_unit,
  output wire [4:0] pkt_net,
  output wire       pkt_fault,
  output wire       pkt_al3,
  output wire       pkt_al2,
  output wire       pkt_al1
);
  reg [14:0] pkt_q;
  initial pkt_q = 15'h0000;
  assign {pkt_valid, pkt_unit, pkt_net, pkt_fault, pkt_al3, pkt_al2, pkt_al1} = pkt_q;
  // al is fault, level three, level two, level one
  task send(input [4:0] unit, input [4:0] net, input [3:0] al);
    begin
      @(posedge pclk);
      pkt_q <= {1'b1, unit, net, al};
      @(posedge pclk);
      pkt_q <= {1'b0, ~unit, ~net, ~al};
    end
  endtask
endmodule // arm_remote_model

// ---- tb_top.sv ----
// Purpose : self-checking bench for arm_mapper
// Assumes : shortened second, minute and pulse dividers
// Notes   : packets come from arm_remote_model
`timescale 1ns/10ps
`include "arm_map.vh"
module tb_top;
  reg         pclk, presetn, psel, penable, pwrite, alarm_reset, fs;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, q;
  reg  [15:0] rnd;
  reg  [3:0]  al;
  wire [31:0] prdata;
  wire        pready, pslverr, pkt_valid, pkt_fault, pkt_al1, pkt_al2, pkt_al3;
  wire        repeat_tx, horn_relay, encrypt_en, high_band;
  wire [4:0]  pkt_unit, pkt_net, hop_channel, system_id;
  wire [3:0]  relay_out;
  integer     err_total, checks_done, i, m, hi;
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  arm_mapper #(.SEC_DIV(10), .MIN_SECS(3), .PULSE_DIV(4)) arm_mapper_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pkt_valid(pkt_valid), .pkt_unit(pkt_unit), .pkt_net(pkt_net), .pkt_fault(pkt_fault),
    .pkt_al1(pkt_al1), .pkt_al2(pkt_al2), .pkt_al3(pkt_al3), .alarm_reset(alarm_reset),
    .repeat_tx(repeat_tx), .relay_out(relay_out), .horn_relay(horn_relay),
    .hop_channel(hop_channel), .system_id(system_id), .encrypt_en(encrypt_en),
    .high_band(high_band));
  arm_remote_model arm_remote_model_inst (
    .pclk(pclk), .pkt_valid(pkt_valid), .pkt_unit(pkt_unit), .pkt_net(pkt_net),
    .pkt_fault(pkt_fault), .pkt_al1(pkt_al1), .pkt_al2(pkt_al2), .pkt_al3(pkt_al3));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function exp_trip(input [2:0] t, input [3:0] a);
    exp_trip = (t == 3'h4) ? |a[2:0] : a[t[1:0]];
  endfunction
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    integer k;
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
        @(posedge pclk);
        k = k + 1;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin
        err_total = err_total + 1;
        complete_run;
      end
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task pk(input [4:0] u, input [4:0] n, input [3:0] a);
    begin
      arm_remote_model_inst.send(u, n, a);
      repeat (3) @(posedge pclk);
    end
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, alarm_reset} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    err_total = 0;
    checks_done = 0;
    rnd = 16'h7730;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `ARM_CFG_OFS, 0);
    chk("cfg_reset", 32'h0F000100, q);
    apb(0, `ARM_UNIT_OFS + 12'h014, 0);
    chk("unit5", 6, q);
    apb(0, 12'h014, 0);
    chk("unmapped", 0, q);
    apb(0, `ARM_WDMAX_OFS, 0);
    chk("wakeup", 300, q[8:0]);
    for (i = 0; i < 27; i = i + 1) begin
      apb(1, `ARM_CFG_OFS, i);
      repeat (2) @(posedge pclk);
      m = (i < 26) ? i : 25;
      chk("hop", m + 1, hop_channel);
      chk("sysid", m + 1, system_id);
      chk("encrypt", m > 11, encrypt_en);
      chk("band", m > 17, high_band);
    end
    apb(0, `ARM_CFG_OFS, 0);
    chk("count", 1, q[13:8]);
    apb(1, `ARM_MASK_OFS, 1);
    for (i = 0; i < 20; i = i + 1) begin
      rnd = lfsr(rnd);
      m = i % 5;
      fs = rnd[4];
      al = rnd[3:0];
      if (m == 4)
        al[3] = 1'b0;
      apb(1, `ARM_RLY_OFS, {22'h0, 2'h2, 3'h0, fs, 1'b0, m[2:0]});
      pk(5'h01, 5'h19, al);
      chk("relay0", exp_trip(m, al) ^ fs, relay_out[0]);
      chk("horn", exp_trip(m, al), horn_relay);
      chk("relay1", 0, relay_out[1]);
    end
    apb(1, `ARM_RLY_OFS, 0);
    pk(5'h01, 5'h19, 4'h0);
    pk(5'h01, 5'h05, 4'h1);
    chk("foreign", 0, relay_out[0]);
    apb(1, `ARM_UNIT_OFS, 7);
    pk(5'h01, 5'h19, 4'h1);
    chk("old_unit", 0, relay_out[0]);
    pk(5'h07, 5'h19, 4'h1);
    chk("new_unit", 1, relay_out[0]);
    chk("horn_none", 0, horn_relay);
    apb(1, `ARM_ACT_OFS, 0);
    repeat (3) @(posedge pclk);
    chk("inactive", 0, relay_out[0]);
    apb(1, `ARM_ACT_OFS, 1);
    apb(1, `ARM_RLY_OFS, 32'h00000120);
    apb(1, `ARM_CFG_OFS, 32'h00020119);
    pk(5'h07, 5'h19, 4'h1);
    hi = 0;
    for (i = 0; i < 16; i = i + 1) begin
      @(posedge pclk);
      hi = hi + horn_relay;
    end
    chk("horn_pulse", 1, hi > 0 && hi < 16);
    chk("ack_before", 1, relay_out[0]);
    alarm_reset <= 1'b1;
    @(posedge pclk);
    alarm_reset <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("ack", 0, relay_out[0]);
    for (i = 0; i < 150 && relay_out[0] !== 1'b1; i = i + 1)
      @(posedge pclk);
    chk("refresh", 1, relay_out[0]);
    chk("refresh_wait", 1, i > 20);
    apb(1, `ARM_CFG_OFS, 32'h00020139);
    arm_remote_model_inst.send(5'h07, 5'h19, 4'h1);
    @(negedge pclk);
    chk("repeat", 1, repeat_tx);
    arm_remote_model_inst.send(5'h07, 5'h03, 4'h1);
    @(negedge pclk);
    chk("repeat_foreign", 0, repeat_tx);
    @(posedge pclk);
    apb(1, `ARM_WDMAX_OFS, 2);
    pk(5'h07, 5'h19, 4'h0);
    repeat (60) @(posedge pclk);
    apb(0, `ARM_CERR_OFS, 0);
    chk("cerr_early", 0, q);
    apb(0, `ARM_WDMAX_OFS, 0);
    chk("wd_max", 1, q[26:16] >= 5 && q[26:16] <= 8);
    repeat (60) @(posedge pclk);
    apb(0, `ARM_CERR_OFS, 0);
    chk("cerr_late", 1, q);
    apb(1, `ARM_RLY_OFS, 3);
    repeat (3) @(posedge pclk);
    chk("relay_comm", 1, relay_out[0]);
    pk(5'h07, 5'h19, 4'h0);
    apb(0, `ARM_CERR_OFS, 0);
    chk("cerr_clear", 0, q);
    complete_run;
  end
endmodule // tb_top
